// file: rtl/csp_pkg.sv
package csp_pkg;
    // Register byte offsets on the APB slave
    localparam logic [7:0] OFF_TIMEOUT_CFG = 8'h00;
    localparam logic [7:0] OFF_SAFE_POS = 8'h04;
    localparam logic [7:0] OFF_REPEAT_SEC = 8'h08;
    localparam logic [7:0] OFF_IRQ_STATUS = 8'h0c;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h10;
    localparam logic [7:0] OFF_STATE = 8'h14;
    localparam logic [7:0] OFF_UMOT_LIMIT = 8'h18;
    // Factory values
    localparam logic [15:0] RST_TIMEOUT_CFG = 16'h0001;
    localparam logic [31:0] RST_SAFE_POS = 32'h0000_0000;
    localparam logic [15:0] RST_REPEAT_SEC = 16'h0000;
    localparam logic [15:0] RST_UMOT_LIMIT = 16'h00b9;
    // Loss reaction codes, bits 1-0
    localparam logic [1:0] LOSS_CONTINUE = 2'h0;
    localparam logic [1:0] LOSS_ABORT = 2'h1;
    localparam logic [1:0] LOSS_SAFE = 2'h2;
    // Power-up wait codes, bits 3-2
    localparam logic [1:0] PWR_NONE = 2'h0;
    localparam logic [1:0] PWR_15 = 2'h1;
    localparam logic [1:0] PWR_30 = 2'h2;
    localparam logic [1:0] PWR_60 = 2'h3;
    localparam int LOSS_LSB = 0;
    localparam int PWR_LSB = 2;
    localparam logic [15:0] PWR_15_SEC = 16'h000f;
    localparam logic [15:0] PWR_30_SEC = 16'h001e;
    localparam logic [15:0] PWR_60_SEC = 16'h003c;
    // Timing: one second at 100 MHz
    localparam int CLK_PERIOD_NS = 10;
    localparam int SECOND_NS = 1000000000;
    localparam int TICKS_PER_SEC = SECOND_NS / CLK_PERIOD_NS;
    // Interrupt bit positions
    localparam int IRQ_LOSS = 0;
    localparam int IRQ_SAFE_START = 1;
    localparam int IRQ_SAFE_FAIL = 2;
    localparam int IRQ_SAFE_DONE = 3;
    localparam int IRQ_BITS = 4;
    // Supervisor states
    typedef enum logic [4:0] {
        ST_WAIT_CONN = 5'h01,
        ST_CONNECTED = 5'h02,
        ST_SAFE_RUN = 5'h04,
        ST_REPEAT_WAIT = 5'h08,
        ST_IDLE = 5'h10
    } csp_state_t;
endpackage

// file: rtl/csp_sec_timer.sv
`timescale 1ns/100ps
`default_nettype none
// Seconds timer: counts down a load value, pulses done at zero
module csp_sec_timer
    import csp_pkg::*;
#(
    parameter int TICKS = TICKS_PER_SEC
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Control
    input wire logic start,
    input wire logic stop,
    input wire logic [15:0] secs,
    // Result
    output logic done
);
    logic [31:0] tick_reg; // Sub-second prescaler
    logic [15:0] sec_reg; // Seconds left
    logic run_reg; // Timer armed

    // Prescaler and second counter
    always_ff @(posedge clk) begin
        if (!rst_b || stop) begin
            run_reg <= 1'b0;
            tick_reg <= 32'h0;
            sec_reg <= 16'h0;
            done <= 1'b0;
        end else if (start) begin
            run_reg <= 1'b1;
            tick_reg <= 32'h0;
            sec_reg <= secs;
            done <= 1'b0;
        end else if (run_reg) begin
            done <= 1'b0;
            if (tick_reg == 32'(TICKS - 1)) begin
                tick_reg <= 32'h0;
                // Last second elapsed
                if (sec_reg <= 16'h1) begin
                    run_reg <= 1'b0;
                    done <= 1'b1;
                end else begin
                    sec_reg <= sec_reg - 16'h1;
                end
            end else begin
                tick_reg <= tick_reg + 32'h1;
            end
        end else begin
            done <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// file: rtl/csp_irq.sv
`timescale 1ns/100ps
`default_nettype none
// Sticky status with write-one-to-clear and mask
module csp_irq
    import csp_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Events and software access
    input wire logic [IRQ_BITS-1:0] events,
    input wire logic [IRQ_BITS-1:0] clear,
    input wire logic mask_we,
    input wire logic [IRQ_BITS-1:0] mask_wdata,
    // State out
    output logic [IRQ_BITS-1:0] status_reg,
    output logic [IRQ_BITS-1:0] mask_reg,
    output logic irq
);
    // Set wins over clear so no event is lost
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            status_reg <= '0;
        end else begin
            status_reg <= (status_reg & ~clear) | events;
        end
    end

    // Mask register
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            mask_reg <= '0;
        end else if (mask_we) begin
            mask_reg <= mask_wdata;
        end
    end

    assign irq = |(status_reg & mask_reg);
endmodule
`default_nettype wire

// file: rtl/csp_supervisor.sv
// Added by the designer: register access over APB and the address map.
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// [RULE1] Loss reaction only after established connection
// [RULE2] Code 0: keep going to target
// [RULE3] Code 1: abort the running move
// [RULE4] Code 2: run to safe position
// [RULE5] No connection at power-up: delayed safe run
// [RULE6] Safe position is signed run target
// [RULE7] Failed safe run repeats after interval
// [RULE8] Interval in seconds, zero disables repeat
// [RULE9] Power-up code 0: no safe run
// [RULE10] Parameters reset to factory values
// [RULE11] Runs start only above voltage limit
module csp_supervisor
    import csp_pkg::*;
#(
    parameter int TICKS = TICKS_PER_SEC
) (
    // Clock and reset
    input wire logic CLK,
    input wire logic RST_B,
    // APB slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // Drive status
    input wire logic CONN_UP,
    input wire logic SAFE_RUN_FAIL,
    input wire logic SAFE_RUN_DONE,
    input wire logic [15:0] UMOT_DECIVOLT,
    // Motion commands
    output logic ABORT_RUN,
    output logic SAFE_RUN_START,
    output logic [31:0] SAFE_RUN_TARGET,
    output logic RUN_ALLOWED,
    // Interrupt
    output logic IRQ
);
    logic [15:0] timeout_cfg_reg; // Reaction configuration
    logic [31:0] safe_pos_reg; // Signed safe target
    logic [15:0] repeat_sec_reg; // Repeat interval
    logic [15:0] umot_limit_reg; // Voltage limit, 0.1 V units
    csp_state_t state_reg; // Supervisor state
    csp_state_t state_next;
    logic conn_seen_reg; // Connection was ever up
    logic conn_d_reg; // Connection delayed copy
    logic loss_evt; // Connection just dropped
    logic pwr_done; // Power-up wait expired
    logic rep_done; // Repeat wait expired
    logic pwr_start; // Load power-up timer
    logic rep_start; // Load repeat timer
    logic safe_go; // Start a safe run now
    logic [15:0] pwr_secs; // Power-up wait in seconds
    logic [1:0] loss_code;
    logic [1:0] pwr_code;
    logic wr_en; // APB write strobe
    logic [IRQ_BITS-1:0] irq_status;
    logic [IRQ_BITS-1:0] irq_mask;
    logic [IRQ_BITS-1:0] irq_clear;
    logic init_reg; // First cycle after reset
    logic cfg_load_reg; // Timeout configuration just written
    logic pwr_stop; // Cancel the power-up wait

    assign loss_code = timeout_cfg_reg[LOSS_LSB +: 2];
    assign pwr_code = timeout_cfg_reg[PWR_LSB +: 2];
    assign wr_en = PSEL && PENABLE && PWRITE;

    // Zero-wait slave; unmapped addresses error
    assign PREADY = 1'b1;
    always_comb begin
        case (PADDR)
            OFF_TIMEOUT_CFG, OFF_SAFE_POS, OFF_REPEAT_SEC, OFF_IRQ_STATUS,
            OFF_IRQ_MASK, OFF_STATE, OFF_UMOT_LIMIT: PSLVERR = 1'b0;
            default: PSLVERR = PSEL && PENABLE;
        endcase
    end

    // Parameter registers, factory values at reset
    // Upper halves of the 16-bit parameters are dropped on write
    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            timeout_cfg_reg <= RST_TIMEOUT_CFG; // see [RULE10]
            safe_pos_reg <= RST_SAFE_POS; // see [RULE10]
            repeat_sec_reg <= RST_REPEAT_SEC; // see [RULE10]
            umot_limit_reg <= RST_UMOT_LIMIT;
        end else if (wr_en) begin
            case (PADDR)
                OFF_TIMEOUT_CFG: timeout_cfg_reg <= PWDATA[15:0];
                OFF_SAFE_POS: safe_pos_reg <= PWDATA;
                OFF_REPEAT_SEC: repeat_sec_reg <= PWDATA[15:0];
                OFF_UMOT_LIMIT: umot_limit_reg <= PWDATA[15:0];
                default: ;
            endcase
        end
    end

    // Read data registered from the setup phase
    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            PRDATA <= 32'h0;
        end else if (PSEL && !PENABLE && !PWRITE) begin
            case (PADDR)
                OFF_TIMEOUT_CFG: PRDATA <= {16'h0, timeout_cfg_reg};
                OFF_SAFE_POS: PRDATA <= safe_pos_reg;
                OFF_REPEAT_SEC: PRDATA <= {16'h0, repeat_sec_reg};
                OFF_IRQ_STATUS: PRDATA <= {28'h0, irq_status};
                OFF_IRQ_MASK: PRDATA <= {28'h0, irq_mask};
                OFF_STATE: PRDATA <= {26'h0, conn_seen_reg, 5'(state_reg)};
                OFF_UMOT_LIMIT: PRDATA <= {16'h0, umot_limit_reg};
                default: PRDATA <= 32'h0;
            endcase
        end
    end

    // Connection history; loss counts only after first contact
    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            conn_d_reg <= 1'b0;
            conn_seen_reg <= 1'b0;
            init_reg <= 1'b1;
        end else begin
            conn_d_reg <= CONN_UP;
            init_reg <= 1'b0;
            if (CONN_UP) begin
                conn_seen_reg <= 1'b1;
            end
        end
    end
    assign loss_evt = conn_seen_reg && conn_d_reg && !CONN_UP; // see [RULE1]

    // Flag a fresh timeout configuration for one cycle
    // The stored value stands in for the backed-up one read at power-up,
    // so a late load still starts the wait while no contact was made
    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            cfg_load_reg <= 1'b0;
        end else begin
            cfg_load_reg <= wr_en && (PADDR == OFF_TIMEOUT_CFG);
        end
    end

    // Power-up wait from bits 3-2
    always_comb begin
        case (pwr_code)
            PWR_15: pwr_secs = PWR_15_SEC; // see [RULE5]
            PWR_30: pwr_secs = PWR_30_SEC;
            PWR_60: pwr_secs = PWR_60_SEC;
            default: pwr_secs = 16'h0;
        endcase
    end
    // Timer armed after reset or a new code, never once contact was made
    assign pwr_start = (init_reg || cfg_load_reg) && !conn_seen_reg
        && (pwr_code != PWR_NONE); // see [RULE9]
    // Contact or code 0 cancels a wait already running
    assign pwr_stop = CONN_UP || (pwr_code == PWR_NONE); // see [RULE9]

    csp_sec_timer #(.TICKS(TICKS)) u_pwr_timer (
        .clk(CLK),
        .rst_b(RST_B),
        .start(pwr_start),
        .stop(pwr_stop),
        .secs(pwr_secs),
        .done(pwr_done)
    );

    // A fail outside a safe run is ignored; the motion logic owns that error
    // Repeat only with a nonzero interval
    assign rep_start = (state_reg == ST_SAFE_RUN) && SAFE_RUN_FAIL
        && (repeat_sec_reg != RST_REPEAT_SEC); // see [RULE8]

    csp_sec_timer #(.TICKS(TICKS)) u_rep_timer (
        .clk(CLK),
        .rst_b(RST_B),
        .start(rep_start),
        .stop(CONN_UP),
        .secs(repeat_sec_reg),
        .done(rep_done)
    );

    // Supervisor next state
    // Contact always wins: any state returns to connected when the link is up,
    // so a loss can only be seen from the connected state.
    // Codes 0 and 3 both park in idle; only code 1 touches the move,
    // and that is done by the abort pulse below, not by a state.
    always_comb begin
        state_next = state_reg;
        safe_go = 1'b0;
        case (state_reg)
            ST_WAIT_CONN: begin
                if (CONN_UP) begin
                    state_next = ST_CONNECTED;
                // Code 0 written during the wait must not launch a run
                end else if (pwr_done && pwr_code != PWR_NONE) begin
                    safe_go = 1'b1; // see [RULE5]
                    state_next = ST_SAFE_RUN;
                end
            end
            ST_CONNECTED: begin
                if (loss_evt && loss_code == LOSS_SAFE) begin
                    safe_go = 1'b1; // see [RULE4]
                    state_next = ST_SAFE_RUN;
                end else if (loss_evt) begin
                    state_next = ST_IDLE; // see [RULE2]
                end
            end
            ST_SAFE_RUN: begin
                if (CONN_UP) begin
                    state_next = ST_CONNECTED;
                end else if (SAFE_RUN_FAIL) begin
                    state_next = rep_start ? ST_REPEAT_WAIT : ST_IDLE; // see [RULE7]
                end else if (SAFE_RUN_DONE) begin
                    state_next = ST_IDLE;
                end
            end
            ST_REPEAT_WAIT: begin
                if (CONN_UP) begin
                    state_next = ST_CONNECTED;
                end else if (rep_done) begin
                    safe_go = 1'b1; // see [RULE7]
                    state_next = ST_SAFE_RUN;
                end
            end
            ST_IDLE: begin
                if (CONN_UP) begin
                    state_next = ST_CONNECTED;
                end
            end
            default: state_next = ST_WAIT_CONN;
        endcase
    end

    // State register
    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            state_reg <= ST_WAIT_CONN;
        end else begin
            state_reg <= state_next;
        end
    end

    // Motion command outputs, registered
    // One cycle of latency buys glitch-free pulses towards the motion logic
    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            ABORT_RUN <= 1'b0;
            SAFE_RUN_START <= 1'b0;
            SAFE_RUN_TARGET <= RST_SAFE_POS;
        end else begin
            // Code 0 leaves the move alone; code 1 aborts
            ABORT_RUN <= (state_reg == ST_CONNECTED) && loss_evt
                && (loss_code == LOSS_ABORT); // see [RULE3]
            SAFE_RUN_START <= safe_go;
            if (safe_go) begin
                SAFE_RUN_TARGET <= safe_pos_reg; // see [RULE6]
            end
        end
    end

    // Voltage gate; run interlock lives in the motion logic
    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            RUN_ALLOWED <= 1'b0;
        end else begin
            RUN_ALLOWED <= UMOT_DECIVOLT > umot_limit_reg; // see [RULE11]
        end
    end

    // Interrupt block
    // Fail and done count only inside a safe run, so stale pulses stay quiet
    assign irq_clear = (wr_en && PADDR == OFF_IRQ_STATUS) ? PWDATA[IRQ_BITS-1:0] : '0;
    csp_irq u_irq (
        .clk(CLK),
        .rst_b(RST_B),
        .events({SAFE_RUN_DONE && state_reg == ST_SAFE_RUN,
                 SAFE_RUN_FAIL && state_reg == ST_SAFE_RUN, safe_go, loss_evt}),
        .clear(irq_clear),
        .mask_we(wr_en && PADDR == OFF_IRQ_MASK),
        .mask_wdata(PWDATA[IRQ_BITS-1:0]),
        .status_reg(irq_status),
        .mask_reg(irq_mask),
        .irq(IRQ)
    );

    // Checks, each next to the rule it guards
    // No abort while contact was never made
    chk_loss_before_conn: assert property (@(posedge CLK) disable iff (!RST_B) // see [RULE1]
        !conn_seen_reg |=> !ABORT_RUN)
        else $error("loss without connection");
    // Code 1 aborts one cycle after the drop
    chk_abort_code: assert property (@(posedge CLK) disable iff (!RST_B) // see [RULE3]
        (state_reg == ST_CONNECTED && loss_evt && loss_code == LOSS_ABORT) |=> ABORT_RUN)
        else $error("abort missing");
    // Code 0 leaves the move running and parks the supervisor
    chk_continue_code: assert property (@(posedge CLK) disable iff (!RST_B) // see [RULE2]
        (loss_evt && loss_code == LOSS_CONTINUE)
        |=> !ABORT_RUN && !SAFE_RUN_START && state_reg == ST_IDLE)
        else $error("continue disturbed");
    // Code 2 starts the safe run one cycle after the drop
    chk_safe_on_loss: assert property (@(posedge CLK) disable iff (!RST_B) // see [RULE4]
        (state_reg == ST_CONNECTED && loss_evt && loss_code == LOSS_SAFE)
        |=> SAFE_RUN_START) else $error("safe run missing");
    // Target is the safe position as it stood at the start
    chk_target_value: assert property (@(posedge CLK) disable iff (!RST_B) // see [RULE6]
        safe_go |=> SAFE_RUN_TARGET == $past(safe_pos_reg))
        else $error("wrong target");
    // Zero interval ends a failed run in idle
    chk_no_repeat_zero: assert property (@(posedge CLK) disable iff (!RST_B) // see [RULE8]
        (state_reg == ST_SAFE_RUN && SAFE_RUN_FAIL && !CONN_UP && repeat_sec_reg == 16'h0)
        |=> state_reg == ST_IDLE) else $error("repeat with zero");
    // Power-up code 0 never launches a run
    chk_pwr_disabled: assert property (@(posedge CLK) disable iff (!RST_B) // see [RULE9]
        (pwr_code == PWR_NONE && state_reg == ST_WAIT_CONN) |-> !safe_go)
        else $error("power-up run disabled");
    // Nonzero interval arms the repeat wait
    chk_repeat_arm: assert property (@(posedge CLK) disable iff (!RST_B) // see [RULE7]
        (state_reg == ST_SAFE_RUN && SAFE_RUN_FAIL && !CONN_UP && repeat_sec_reg != 16'h0)
        |=> state_reg == ST_REPEAT_WAIT) else $error("repeat not armed");
    // End of the repeat wait starts the next run
    chk_repeat_fires: assert property (@(posedge CLK) disable iff (!RST_B) // see [RULE7]
        (state_reg == ST_REPEAT_WAIT && rep_done && !CONN_UP)
        |=> SAFE_RUN_START) else $error("repeat run missing");
    // End of the power-up wait starts the safe run
    chk_pwr_run_start: assert property (@(posedge CLK) disable iff (!RST_B) // see [RULE5]
        (state_reg == ST_WAIT_CONN && pwr_done && pwr_code != PWR_NONE && !CONN_UP)
        |=> SAFE_RUN_START) else $error("power-up run missing");
    // Factory values follow every reset cycle
    chk_factory_values: assert property (@(posedge CLK) !RST_B |=> // see [RULE10]
        timeout_cfg_reg == RST_TIMEOUT_CFG && safe_pos_reg == RST_SAFE_POS
        && repeat_sec_reg == RST_REPEAT_SEC) else $error("factory values lost");
    // No run permission at or below the limit
    chk_volt_gate: assert property (@(posedge CLK) disable iff (!RST_B) // see [RULE11]
        (UMOT_DECIVOLT <= umot_limit_reg) |=> !RUN_ALLOWED)
        else $error("run allowed undervoltage");
    // Main scenarios
    cov_loss_safe: cover property (@(posedge CLK) disable iff (!RST_B)
        loss_evt && loss_code == LOSS_SAFE);
    cov_loss_abort: cover property (@(posedge CLK) disable iff (!RST_B)
        loss_evt && loss_code == LOSS_ABORT);
    cov_pwr_run: cover property (@(posedge CLK) disable iff (!RST_B)
        state_reg == ST_WAIT_CONN && pwr_done);
    cov_repeat: cover property (@(posedge CLK) disable iff (!RST_B)
        state_reg == ST_REPEAT_WAIT && rep_done);
    cov_safe_done: cover property (@(posedge CLK) disable iff (!RST_B)
        state_reg == ST_SAFE_RUN && SAFE_RUN_DONE);
endmodule
`default_nettype wire

// file: test/csp_drive_model.sv
`timescale 1ns/100ps
`default_nettype none
// Drive model: answers each safe run with done or fail after a short travel
module csp_drive_model (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Command and mode
    input wire logic start,
    input wire logic fail_mode,
    // Run result pulses
    output logic fail,
    output logic done
);
    logic [2:0] run_cnt; // Travel time left, zero when idle
    // One result pulse per run; a new start restarts the travel
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            run_cnt <= 3'h0;
            fail <= 1'b0;
            done <= 1'b0;
        end else if (start) begin
            run_cnt <= 3'h5;
            fail <= 1'b0;
            done <= 1'b0;
        end else begin
            if (run_cnt != 3'h0) begin
                run_cnt <= run_cnt - 3'h1;
            end
            // Result on the last step of travel
            fail <= (run_cnt == 3'h1) && fail_mode;
            done <= (run_cnt == 3'h1) && !fail_mode;
        end
    end
endmodule
`default_nettype wire

// file: test/csp_supervisor_tb.sv
`timescale 1ns/100ps
`default_nettype none
module csp_supervisor_tb;
    import csp_pkg::*;
    typedef struct {logic wr; logic [7:0] a; logic [31:0] d; logic [31:0] e; logic er;} csp_row_t;
    logic clk = 1'b0, rst_b = 1'b0; // Clock and reset
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0; // APB request
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rdata, target, tgt;
    logic pready, pslverr, err, irq, abort_run, safe_start, run_allowed;
    logic conn = 1'b0, fail_mode = 1'b0, run_fail, run_done; // Drive side
    logic [15:0] umot = 16'h00c8;
    int n_fail = 0, n_checks = 0, n_abort = 0, n_start = 0, cyc = 0, t_start = 0, t_fail = 0;
    int na, ns, t_cfg;
    // Register map rows: access, address, write data, expected read, error
    csp_row_t rows [12] = '{
        '{0, 8'h00, 0, 32'h1, 0}, '{0, 8'h04, 0, 32'h0, 0}, '{0, 8'h08, 0, 32'h0, 0},
        '{0, 8'h10, 0, 32'h0, 0}, '{0, 8'h18, 0, 32'hb9, 0}, '{1, 8'h14, 32'hff, 0, 0},
        '{0, 8'h14, 0, 32'h1, 0}, '{1, 8'h04, 32'hffff_ff00, 0, 0},
        '{0, 8'h04, 0, 32'hffff_ff00, 0}, '{1, 8'h08, 32'h1_2345, 0, 0},
        '{0, 8'h08, 0, 32'h2345, 0}, '{0, 8'h1c, 0, 32'h0, 1}};
    always #5 clk = ~clk;
    csp_supervisor #(.TICKS(10)) csp_supervisor_inst (.CLK(clk), .RST_B(rst_b), .PSEL(psel),
        .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .CONN_UP(conn), .SAFE_RUN_FAIL(run_fail),
        .SAFE_RUN_DONE(run_done), .UMOT_DECIVOLT(umot), .ABORT_RUN(abort_run),
        .SAFE_RUN_START(safe_start), .SAFE_RUN_TARGET(target), .RUN_ALLOWED(run_allowed),
        .IRQ(irq));
    csp_drive_model csp_drive_model_inst (.clk(clk), .rst_b(rst_b), .start(safe_start),
        .fail_mode(fail_mode), .fail(run_fail), .done(run_done));
    // Monitor of command pulses, each stands one cycle
    always @(posedge clk) begin
        if (abort_run === 1'b1) n_abort++;
        if (safe_start === 1'b1) begin
            n_start++;
            t_start = cyc;
            tgt = target;
        end
        if (run_fail === 1'b1) t_fail = cyc;
        cyc++;
    end
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    // One APB transfer; holds the request until pready is seen high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // No assumed latency; only the watchdog ends a stuck access
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rdata = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            n_fail++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic give_verdict();
        $display("Checks %0d, mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // Watchdog, far beyond the expected run of about 750 cycles
    initial begin
        #200000;
        n_fail++;
        give_verdict();
    end
    // Main sequence
    initial begin
        wait_cyc(4);
        rst_b <= 1'b1;
        // No connection yet and power-up wait code 0: nothing starts
        wait_cyc(200);
        chk("idle starts", 0, n_start + n_abort);
        foreach (rows[i]) begin
            apb(rows[i].wr, rows[i].a, rows[i].d);
            if (!rows[i].wr) chk("read data", rows[i].e, rdata);
            chk("slave error", rows[i].er, err);
        end
        $display("Test register map done");
        // Every loss reaction code, each after a fresh connection
        for (int c = 0; c < 4; c++) begin
            apb(1'b1, OFF_TIMEOUT_CFG, c);
            conn <= 1'b1;
            wait_cyc(4);
            na = n_abort;
            ns = n_start;
            conn <= 1'b0;
            wait_cyc(4);
            chk("abort count", c == 1, n_abort - na);
            chk("start count", c == 2, n_start - ns);
            if (c == 2) chk("safe target", 32'hffff_ff00, tgt);
            conn <= 1'b1;
            wait_cyc(10);
        end
        $display("Test loss reactions done");
        // Failed safe runs repeat after three seconds, none once zero
        apb(1'b1, OFF_REPEAT_SEC, 32'h3);
        apb(1'b1, OFF_TIMEOUT_CFG, 32'h2);
        fail_mode <= 1'b1;
        ns = n_start;
        conn <= 1'b0;
        for (int i = 0; i < 200 && n_start < ns + 2; i++) @(posedge clk);
        chk("repeat seen", 1, n_start >= ns + 2);
        chk("repeat wait", 1, t_start - t_fail >= 30 && t_start - t_fail <= 34);
        apb(1'b1, OFF_REPEAT_SEC, 32'h0);
        wait_cyc(60);
        ns = n_start;
        wait_cyc(80);
        chk("no repeat", 0, n_start - ns);
        conn <= 1'b1;
        fail_mode <= 1'b0;
        wait_cyc(10);
        $display("Test repeat done");
        // Interrupt masked, unmasked, then cleared
        apb(1'b1, OFF_IRQ_MASK, 32'h0);
        wait_cyc(2);
        chk("irq masked", 0, irq);
        apb(1'b1, OFF_IRQ_MASK, 32'hf);
        wait_cyc(2);
        chk("irq raised", 1, irq);
        apb(1'b1, OFF_IRQ_STATUS, 32'hf);
        apb(1'b0, OFF_IRQ_STATUS, 32'h0);
        chk("status clear", 0, rdata);
        chk("irq cleared", 0, irq);
        $display("Test interrupt done");
        // Motor voltage against the limit of 18.5 V
        umot <= 16'h00b9;
        wait_cyc(3);
        chk("run at limit", 0, run_allowed);
        umot <= 16'h00ba;
        wait_cyc(3);
        chk("run above limit", 1, run_allowed);
        $display("Test voltage done");
        // Reset in mid-run restores factory values
        apb(1'b1, OFF_TIMEOUT_CFG, 32'h6);
        rst_b <= 1'b0;
        conn <= 1'b0;
        wait_cyc(4);
        rst_b <= 1'b1;
        apb(1'b0, OFF_TIMEOUT_CFG, 32'h0);
        chk("cfg after reset", 32'h1, rdata);
        apb(1'b0, OFF_SAFE_POS, 32'h0);
        chk("pos after reset", 32'h0, rdata);
        $display("Test second reset done");
        // Still no contact: wait code 1 gives a safe run after 15 s
        apb(1'b1, OFF_SAFE_POS, 32'h8000_0010);
        apb(1'b1, OFF_TIMEOUT_CFG, 32'h4);
        t_cfg = cyc;
        ns = n_start;
        for (int i = 0; i < 300 && n_start == ns; i++) @(posedge clk);
        chk("power-up start", 1, n_start - ns);
        chk("power-up wait", 1, t_start - t_cfg >= 150 && t_start - t_cfg <= 156);
        chk("power-up target", 32'h8000_0010, tgt);
        wait_cyc(10);
        apb(1'b0, OFF_IRQ_STATUS, 32'h0);
        chk("power-up status", 32'ha, rdata);
        $display("Test power-up run done");
        give_verdict();
    end
endmodule
`default_nettype wire
